// [sim/tb_timer_counter_prescale_core.sv]
`default_nettype none
module tb_timer_counter_prescale_core
    import tpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic clk;
    logic rst;
    tpc_axi_req_s req;
    tpc_axi_rsp_s rsp;
    logic fix_clk;
    logic ext_clk;
    logic dbg;
    logic [15:0] count;
    logic down;
    logic ovf;
    logic center_aligned_pwm;
    logic irq;
    logic [33:0] exp_q[$];
    int failures;
    int n_tests;
    int n;
    int k;
    logic [7:0] m;
    logic [15:0] cnt;
    logic [7:0] regs [5];

    tpc_core u_dut (
        .ref_clk_in(clk),
        .reset_in(rst),
        .axi_in(req),
        .axi_out(rsp),
        .fixed_clock_in(fix_clk),
        .ext_clock_in(ext_clk),
        .debug_mode_in(dbg),
        .count_out(count),
        .count_down_out(down),
        .overflow_out(ovf),
        .center_aligned_pwm_out(center_aligned_pwm),
        .irq_out(irq)
    );

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        failures++;
        $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    // write one byte; master holds each channel until taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] r = TPC_RESP_OKAY);
        int i;
        @(posedge clk);
        exp_q.push_back({r, 32'h00000000});
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && i < 50);
        req.bready <= 1'b0;
        if (i >= 50) timeout();
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] d,
                          input logic [1:0] r = TPC_RESP_OKAY);
        int i;
        @(posedge clk);
        exp_q.push_back({r, 24'h000000, d});
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && i < 50);
        req.rready <= 1'b0;
        if (i >= 50) timeout();
    endtask

    // source edges at a quarter of the bus rate
    task automatic pulse(input logic use_ext, input int cnt_p);
        repeat (cnt_p) begin
            @(posedge clk);
            if (use_ext) ext_clk <= 1'b1; else fix_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clk <= 1'b0;
            fix_clk <= 1'b0;
            @(posedge clk);
        end
        repeat (6) @(posedge clk);
    endtask

    task automatic wait_ovf(output int w);
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (ovf !== 1'b1 && w < 5000);
        if (w >= 5000) timeout();
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
            check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        end else if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
            check({rsp.bresp, 32'h00000000}, exp_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        req = '0;
        fix_clk = 1'b0;
        ext_clk = 1'b0;
        dbg = 1'b0;
        failures = 0;
        n_tests = 0;
        regs = '{TPC_OFS_STATUS, TPC_OFS_CNT_H, TPC_OFS_CNT_L, TPC_OFS_MOD_H, TPC_OFS_MOD_L};
        void'($urandom(32'h1831));
        m = 8'(3 + $urandom % 6);
        cnt = 16'(250 + $urandom % 50);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) axi_rd(regs[i], 8'h00);
        axi_rd(8'h14, 8'h00, TPC_RESP_SLVERR);
        axi_wr(8'h14, 8'hFF, TPC_RESP_SLVERR);
        axi_wr(TPC_OFS_CNT_H, 8'(~m));
        axi_rd(TPC_OFS_CNT_H, 8'h00);
        $display("test reset_values done");
        axi_wr(TPC_OFS_MOD_H, 8'h00);
        axi_wr(TPC_OFS_MOD_L, m);
        foreach (regs[i]) begin
            if (i < 3) begin
                axi_wr(TPC_OFS_STATUS, 8'h08 | 8'(i * i + i / 2));
                wait_ovf(n);
                wait_ovf(n);
                check(34'(n), 34'((m + 1) << (i * i + i / 2)));
            end
        end
        $display("test up_period done");
        axi_wr(TPC_OFS_STATUS, 8'h80);
        axi_rd(TPC_OFS_STATUS, 8'h80);
        axi_wr(TPC_OFS_STATUS, 8'h40);
        axi_rd(TPC_OFS_STATUS, 8'h40);
        check(34'(irq), 34'h0);
        axi_wr(TPC_OFS_STATUS, 8'h48);
        wait_ovf(n);
        repeat (2) @(posedge clk);
        check(34'(irq), 34'h1);
        axi_rd(TPC_OFS_STATUS, 8'hC8);
        wait_ovf(n);
        axi_wr(TPC_OFS_STATUS, 8'h40);
        axi_rd(TPC_OFS_STATUS, 8'hC0);
        axi_wr(TPC_OFS_STATUS, 8'h80);
        axi_rd(TPC_OFS_STATUS, 8'h80);
        check(34'(irq), 34'h0);
        $display("test overflow_flag done");
        axi_wr(TPC_OFS_MOD_H, 8'h00);
        axi_wr(TPC_OFS_MOD_L, 8'h00);
        axi_wr(TPC_OFS_STATUS, 8'h18);
        axi_wr(TPC_OFS_CNT_L, 8'($urandom));
        pulse(1'b1, cnt);
        check(34'(count), 34'(cnt));
        axi_rd(TPC_OFS_CNT_H, cnt[15:8]);
        pulse(1'b1, 5);
        axi_rd(TPC_OFS_CNT_L, cnt[7:0]);
        axi_rd(TPC_OFS_CNT_L, 8'(cnt + 5));
        axi_wr(TPC_OFS_STATUS, 8'h18);
        pulse(1'b1, 3);
        axi_rd(TPC_OFS_CNT_L, 8'(cnt + 8));
        axi_rd(TPC_OFS_CNT_H, 8'((cnt + 8) >> 8));
        dbg <= 1'b1;
        pulse(1'b1, 4);
        check(34'(count), 34'(cnt + 8));
        dbg <= 1'b0;
        axi_wr(TPC_OFS_STATUS, 8'h11);
        axi_wr(TPC_OFS_CNT_H, 8'h5A);
        pulse(1'b0, 6);
        check(34'(count), 34'h3);
        $display("test count_read done");
        axi_wr(TPC_OFS_MOD_H, 8'h00);
        axi_wr(TPC_OFS_MOD_L, m);
        axi_wr(TPC_OFS_STATUS, 8'h08);
        axi_wr(TPC_OFS_MOD_H, 8'h00);
        k = 0;
        repeat (40) begin
            @(posedge clk);
            if (ovf === 1'b1) k++;
        end
        check(34'(k), 34'h0);
        axi_wr(TPC_OFS_STATUS, 8'h08);
        wait_ovf(n);
        $display("test modulo_pair done");
        axi_wr(TPC_OFS_STATUS, 8'h28);
        wait_ovf(n);
        wait_ovf(n);
        check(34'(n), 34'(2 * m));
        #1;
        check({32'h0, down, center_aligned_pwm}, 34'h3);
        @(posedge clk);
        dbg <= 1'b1;
        axi_wr(TPC_OFS_MOD_H, 8'h00);
        axi_wr(TPC_OFS_MOD_L, 8'(m + 1));
        axi_rd(TPC_OFS_MOD_L, m);
        dbg <= 1'b0;
        repeat (3) wait_ovf(n);
        check(34'(n), 34'(2 * (m + 1)));
        axi_rd(TPC_OFS_MOD_L, 8'(m + 1));
        $display("test center done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/tpc_core.sv]
`default_nettype none
module tpc_core
    import tpc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire tpc_axi_req_s axi_in,
    output var tpc_axi_rsp_s axi_out,
    input wire logic fixed_clock_in,
    input wire logic ext_clock_in,
    input wire logic debug_mode_in,
    output logic [15:0] count_out,
    output logic count_down_out,
    output logic overflow_out,
    output logic center_aligned_pwm_out,
    output logic irq_out
);

    tpc_state_s s;
    tpc_state_s next_s;
    logic src_pulse;
    logic tick;
    logic at_top;
    logic raw_ovf;
    logic ovf_evt;
    logic partial;
    logic aw_ok;
    logic w_ok;
    logic ar_ok;
    logic wr_go;
    logic wr_map;
    logic st_wr;
    logic cnt_wr;
    logic modh_wr;
    logic modl_wr;
    logic cnt_hi;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [7:0] one_hot;
    logic [6:0] mask;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        // two-flop sync plus edge stage
        next_s.ext_sync = {s.ext_sync[1:0], ext_clock_in};
        next_s.fix_sync = {s.fix_sync[1:0], fixed_clock_in};

        // source select then prescaler
        case (s.clock_source_select)
            TPC_CS_BUS: src_pulse = 1'b1;
            TPC_CS_FIXED: src_pulse = s.fix_sync[1] & ~s.fix_sync[2];
            TPC_CS_EXT: src_pulse = s.ext_sync[1] & ~s.ext_sync[2];
            default: src_pulse = 1'b0;
        endcase
        one_hot = 8'h01 << s.prescale_select;
        mask = 7'(one_hot - 8'h01);
        tick = src_pulse && !debug_mode_in && ((s.pre & mask) == mask);
        if (src_pulse && !debug_mode_in) begin
            next_s.pre = s.pre + TPC_PRE_ONE;
        end

        // counter step
        if (s.modulo == TPC_COUNT_ZERO) begin
            at_top = (s.count == TPC_COUNT_MAX);
        end else begin
            at_top = (s.count == s.modulo);
        end
        raw_ovf = 1'b0;
        if (tick) begin
            if (!s.center_aligned_select) begin
                if (at_top) begin
                    next_s.count = TPC_COUNT_ZERO;
                    raw_ovf = 1'b1;
                end else begin
                    next_s.count = s.count + TPC_COUNT_ONE;
                end
            end else if (!s.down) begin
                if (s.count == s.modulo) begin
                    next_s.down = 1'b1;
                    next_s.count = s.count - TPC_COUNT_ONE;
                    raw_ovf = 1'b1;
                end else begin
                    next_s.count = s.count + TPC_COUNT_ONE;
                end
            end else if (s.count == TPC_COUNT_ZERO) begin
                next_s.down = 1'b0;
                next_s.count = TPC_COUNT_ONE;
            end else begin
                next_s.count = s.count - TPC_COUNT_ONE;
            end
        end
        partial = s.mod_got_h | s.mod_got_l;
        ovf_evt = raw_ovf && !partial;
        next_s.ovf_q = ovf_evt;
        if (raw_ovf && s.mod_ready) begin
            next_s.modulo = {s.mod_buf_h, s.mod_buf_l};
            next_s.mod_ready = 1'b0;
        end

        // bus write channels
        aw_ok = axi_in.awvalid && !s.aw_held && !s.bvalid;
        w_ok = axi_in.wvalid && !s.w_held && !s.bvalid;
        if (aw_ok) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = axi_in.awaddr;
        end
        if (w_ok) begin
            next_s.w_held = 1'b1;
            next_s.w_data = axi_in.wdata[7:0];
            next_s.w_en = axi_in.wstrb[0];
        end
        if (s.bvalid && axi_in.bready) begin
            next_s.bvalid = 1'b0;
        end
        wr_go = s.aw_held && s.w_held && !s.bvalid;
        wr_map = s.aw_addr inside {TPC_OFS_STATUS, TPC_OFS_CNT_H, TPC_OFS_CNT_L,
                                   TPC_OFS_MOD_H, TPC_OFS_MOD_L};
        wbyte = s.w_data;
        st_wr = wr_go && s.w_en && (s.aw_addr == TPC_OFS_STATUS);
        cnt_wr = wr_go && s.w_en &&
                 ((s.aw_addr == TPC_OFS_CNT_H) || (s.aw_addr == TPC_OFS_CNT_L));
        modh_wr = wr_go && s.w_en && (s.aw_addr == TPC_OFS_MOD_H);
        modl_wr = wr_go && s.w_en && (s.aw_addr == TPC_OFS_MOD_L);
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_map ? TPC_RESP_OKAY : TPC_RESP_SLVERR;
        end

        // bus read channel
        ar_ok = axi_in.arvalid && !s.rvalid;
        cnt_hi = (axi_in.araddr == TPC_OFS_CNT_H);
        rbyte = TPC_BYTE_ZERO;
        if (s.rvalid && axi_in.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_ok) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = TPC_RESP_OKAY;
            case (axi_in.araddr)
                TPC_OFS_STATUS: begin
                    rbyte = {s.overflow_flag, s.overflow_irq_enable,
                             s.center_aligned_select, s.clock_source_select,
                             s.prescale_select};
                    if (s.overflow_flag) begin
                        next_s.clr_armed = 1'b1;
                    end
                end
                TPC_OFS_CNT_H, TPC_OFS_CNT_L: begin
                    if (s.latched) begin
                        rbyte = cnt_hi ? s.latch[15:8] : s.latch[7:0];
                    end else begin
                        rbyte = cnt_hi ? s.count[15:8] : s.count[7:0];
                    end
                    if (!debug_mode_in) begin
                        if (!s.latched) begin
                            next_s.latched = 1'b1;
                            next_s.latch = s.count;
                            next_s.latch_hi_first = cnt_hi;
                        end else if (cnt_hi != s.latch_hi_first) begin
                            next_s.latched = 1'b0;
                        end
                    end
                end
                TPC_OFS_MOD_H: rbyte = s.modulo[15:8];
                TPC_OFS_MOD_L: rbyte = s.modulo[7:0];
                default: next_s.rresp = TPC_RESP_SLVERR;
            endcase
            next_s.rdata = rbyte;
        end

        // register write effects
        if (st_wr) begin
            if (!wbyte[TPC_SC_FLAG] && s.clr_armed) begin
                next_s.overflow_flag = 1'b0;
            end
            next_s.clr_armed = 1'b0;
            next_s.overflow_irq_enable = wbyte[TPC_SC_IE];
            next_s.center_aligned_select = wbyte[TPC_SC_CENTER];
            next_s.clock_source_select = tpc_clk_src_e'(wbyte[TPC_SC_CS_HI:TPC_SC_CS_LO]);
            next_s.prescale_select = wbyte[TPC_SC_PS_HI:TPC_SC_PS_LO];
            next_s.latched = 1'b0;
            next_s.mod_got_h = 1'b0;
            next_s.mod_got_l = 1'b0;
            next_s.mod_ready = 1'b0;
        end
        if (cnt_wr) begin
            next_s.count = TPC_COUNT_ZERO;
            next_s.down = 1'b0;
            next_s.pre = '0;
            next_s.latched = 1'b0;
        end
        if (modh_wr) begin
            next_s.mod_buf_h = wbyte;
            next_s.mod_got_h = 1'b1;
        end
        if (modl_wr) begin
            next_s.mod_buf_l = wbyte;
            next_s.mod_got_l = 1'b1;
        end
        if (next_s.mod_got_h && next_s.mod_got_l) begin
            next_s.mod_got_h = 1'b0;
            next_s.mod_got_l = 1'b0;
            if (!s.center_aligned_select) begin
                next_s.modulo = {next_s.mod_buf_h, next_s.mod_buf_l};
            end else begin
                next_s.mod_ready = 1'b1;
            end
        end

        // overflow set wins over clear
        if (ovf_evt) begin
            next_s.overflow_flag = 1'b1;
            next_s.clr_armed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            s <= TPC_STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign axi_out.awready = !s.aw_held && !s.bvalid;
    assign axi_out.wready = !s.w_held && !s.bvalid;
    assign axi_out.bvalid = s.bvalid;
    assign axi_out.bresp = s.bresp;
    assign axi_out.arready = !s.rvalid;
    assign axi_out.rvalid = s.rvalid;
    assign axi_out.rdata = {TPC_RDATA_PAD, s.rdata};
    assign axi_out.rresp = s.rresp;
    assign count_out = s.count;
    assign count_down_out = s.down;
    assign overflow_out = s.ovf_q;
    assign center_aligned_pwm_out = s.center_aligned_select;
    assign irq_out = s.overflow_flag && s.overflow_irq_enable && !partial;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    a_up_wrap: assert property (
        (tick && !s.center_aligned_select && s.modulo != TPC_COUNT_ZERO
         && s.count == s.modulo && !partial && !cnt_wr)
        |=> (s.count == TPC_COUNT_ZERO) && overflow_out && s.overflow_flag)
        else $error("up count did not wrap to zero with overflow");

    a_center_turn: assert property (
        (tick && s.center_aligned_select && !s.down && s.count == s.modulo
         && s.modulo != TPC_COUNT_ZERO && !cnt_wr && !partial)
        |=> s.down && (s.count == $past(s.count) - TPC_COUNT_ONE) && overflow_out)
        else $error("center count did not turn down at modulo");

    a_ovf_sets_flag: assert property (
        overflow_out |-> s.overflow_flag && !s.clr_armed)
        else $error("overflow did not leave flag set and sequence reset");

    a_one_no_effect: assert property (
        (st_wr && wbyte[TPC_SC_FLAG] && s.overflow_flag) |=> s.overflow_flag)
        else $error("writing one changed the flag");

    a_clear_needs_read: assert property (
        (st_wr && !s.clr_armed && s.overflow_flag) |=> s.overflow_flag)
        else $error("flag cleared without prior read");

    a_irq_on_flag: assert property (
        $rose(s.overflow_flag) && s.overflow_irq_enable && !partial |-> irq_out)
        else $error("interrupt missing with enable and flag");

    a_stop_holds: assert property (
        (s.clock_source_select == TPC_CS_STOP && !cnt_wr) |=> $stable(s.count))
        else $error("counter moved with no clock selected");

    a_ext_sync: assert property (
        (tick && s.clock_source_select == TPC_CS_EXT && s.prescale_select == 3'h0)
        |-> $past(ext_clock_in, 2) && !$past(ext_clock_in, 3))
        else $error("external edge not taken through sync");

    a_prescale_two: assert property (
        (tick && s.clock_source_select == TPC_CS_BUS && s.prescale_select == 3'h1 && !st_wr)
        |=> !tick)
        else $error("divide by two ticked twice in a row");

    a_debug_freeze: assert property (
        (debug_mode_in && !cnt_wr && !st_wr) |=> $stable(s.count) && $stable(s.latched))
        else $error("counter or latch moved in debug");

    a_mod_suppress: assert property (
        (s.mod_got_h != s.mod_got_l) |=> !overflow_out)
        else $error("overflow flagged with half-written modulo");

    a_latch_hold: assert property (
        (s.latched && !cnt_wr && !st_wr && !ar_ok) |=> s.latched && $stable(s.latch))
        else $error("read latch dropped without cause");

    a_latch_release: assert property (
        (cnt_wr || st_wr) |=> !s.latched)
        else $error("read latch kept after count or status write");

    a_count_clear: assert property (
        cnt_wr |=> (s.count == TPC_COUNT_ZERO) && !s.down)
        else $error("count write did not clear the counter");

    a_center_load: assert property (
        (raw_ovf && s.mod_ready)
        |=> s.modulo == {$past(s.mod_buf_h), $past(s.mod_buf_l)})
        else $error("buffered modulo not loaded at overflow step");

    c_up_overflow: cover property (overflow_out && !s.center_aligned_select);
    c_center_turn: cover property (overflow_out && s.center_aligned_select);
    c_flag_cleared: cover property ($fell(s.overflow_flag));
    c_center_load: cover property (raw_ovf && s.mod_ready);
    c_latch_pair: cover property ($fell(s.latched) && !$past(cnt_wr) && !$past(st_wr));

endmodule
`default_nettype wire

// [verilog/tpc_pkg.sv]
`default_nettype none
package tpc_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } tpc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tpc_axi_rsp_s;

    typedef enum logic [1:0] {
        TPC_CS_STOP,
        TPC_CS_BUS,
        TPC_CS_FIXED,
        TPC_CS_EXT
    } tpc_clk_src_e;

    localparam logic [7:0] TPC_OFS_STATUS = 8'h00;
    localparam logic [7:0] TPC_OFS_CNT_H = 8'h04;
    localparam logic [7:0] TPC_OFS_CNT_L = 8'h08;
    localparam logic [7:0] TPC_OFS_MOD_H = 8'h0C;
    localparam logic [7:0] TPC_OFS_MOD_L = 8'h10;

    localparam logic [1:0] TPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPC_RESP_SLVERR = 2'h2;

    localparam int TPC_SC_FLAG = 7;
    localparam int TPC_SC_IE = 6;
    localparam int TPC_SC_CENTER = 5;
    localparam int TPC_SC_CS_HI = 4;
    localparam int TPC_SC_CS_LO = 3;
    localparam int TPC_SC_PS_HI = 2;
    localparam int TPC_SC_PS_LO = 0;

    localparam logic [15:0] TPC_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] TPC_COUNT_ONE = 16'h0001;
    localparam logic [15:0] TPC_COUNT_MAX = 16'hFFFF;
    localparam logic [6:0] TPC_PRE_ONE = 7'h01;
    localparam logic [7:0] TPC_BYTE_ZERO = 8'h00;
    localparam logic [23:0] TPC_RDATA_PAD = 24'h000000;

    typedef struct packed {
        logic [2:0] ext_sync;
        logic [2:0] fix_sync;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic overflow_flag;
        logic clr_armed;
        logic overflow_irq_enable;
        logic center_aligned_select;
        tpc_clk_src_e clock_source_select;
        logic [2:0] prescale_select;
        logic [6:0] pre;
        logic [15:0] count;
        logic down;
        logic ovf_q;
        logic [15:0] modulo;
        logic [7:0] mod_buf_h;
        logic [7:0] mod_buf_l;
        logic mod_got_h;
        logic mod_got_l;
        logic mod_ready;
        logic latched;
        logic latch_hi_first;
        logic [15:0] latch;
    } tpc_state_s;

    localparam tpc_state_s TPC_STATE_RST = '0;

endpackage
`default_nettype wire
